// ---- hw/residual_overvoltage_stage.sv ----
// Implementation choices: the placing of the registers and the APB interface to the registers.
`timescale 1ns/100ps
module residual_overvoltage_stage
  import neutral_overvoltage_pkg::*;
#(
  parameter int unsigned TICK_CYCLES = TICK_CYCLES_DEFAULT
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] calculated_residual,
  input wire logic [15:0] third_channel_residual,
  input wire logic [15:0] fourth_channel_residual,
  input wire logic line_neutral_connected,
  input wire logic third_channel_available,
  input wire logic fourth_channel_available,
  input wire logic block_in,
  output logic start,
  output logic trip,
  output logic blocked,
  output logic block_event,
  output logic [15:0] event_voltage,
  output logic [1:0] event_fault_type,
  output logic hmi_flag
);

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic force_en;
    logic [1:0] force_status;
    logic sw_block;
    logic delayed_release;
    logic [1:0] chan_sel;
    logic [15:0] threshold_value;
    logic [1:0] delay_type;
    logic [18:0] fixed_delay;
    logic [12:0] time_dial;
    logic [11:0] exponent;
    logic [18:0] release_delay;
    logic [31:0] tick_count;
    phase_type phase;
    logic [15:0] measured_magnitude;
    logic blk;
    logic [1:0] chan_code;
    logic [31:0] div_q;
    logic [32:0] div_rem;
    logic [31:0] div_den;
    logic [5:0] div_iter;
    logic [31:0] ratio_q16;
    logic [16:0] ratio_pct;
    logic pickup;
    logic running;
    logic releasing;
    logic [18:0] elapsed;
    logic [18:0] expected;
    logic [18:0] remaining;
    logic [18:0] release_cnt;
    logic start_int;
    logic trip_int;
    logic blocked_int;
    logic start;
    logic trip;
    logic blocked;
    logic block_event;
    logic [15:0] event_voltage;
    logic [1:0] event_fault_type;
    logic hmi_flag;
  } state_type;

  state_type r;
  state_type next_r;

  // ----------------------------------------------------------------
  // fixed point helpers
  // ----------------------------------------------------------------
  function automatic logic [4:0] msb_index(input logic [31:0] x);
    logic [4:0] idx;
    idx = 5'd0;
    for (int i = 0; i < 32; i++) begin
      if (x[i]) begin
        idx = 5'(i);
      end
    end
    return idx;
  endfunction : msb_index

  // log2 of a q16 value >= 1, linear between powers of two
  function automatic logic [19:0] log2_q16(input logic [31:0] x);
    logic [4:0] p;
    logic [31:0] norm;
    p = msb_index(x);
    norm = x << (5'd31 - p);
    return {4'(p - 5'd16), norm[30:15]};
  endfunction : log2_q16

  // 2 to the power y in q16; returns all ones when out of range
  function automatic logic [31:0] exp2_q16(input logic [41:0] y);
    logic [31:0] mant;
    mant = {15'h0000, 1'b1, y[15:0]};
    if (y[41:16] > 26'd14) begin
      return 32'hFFFFFFFF;
    end
    return mant << y[19:16];
  endfunction : exp2_q16

  function automatic logic [18:0] sat_ticks(input logic [31:0] x);
    return (x > 32'(MAX_OPERATE_TICKS)) ? MAX_OPERATE_TICKS : x[18:0];
  endfunction : sat_ticks

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    logic [15:0] sel_meas;
    logic [1:0] sel_code;
    logic [32:0] shifted;
    logic [31:0] pow_q16;
    logic [41:0] scaled_log;
    logic [47:0] pct_wide;
    logic [22:0] meas_x100;
    logic [22:0] thr_x97;
    logic pick_now;
    logic blocked_rise;
    logic access;
    next_r = r;
    sel_meas = 16'h0000;
    sel_code = CHAN_NONE;
    shifted = 33'h000000000;
    pow_q16 = 32'h00000000;
    scaled_log = 42'h00000000000;
    pct_wide = 48'h000000000000;
    meas_x100 = 23'h000000;
    thr_x97 = 23'h000000;
    pick_now = 1'b0;
    blocked_rise = 1'b0;
    access = psel && penable && r.pready;

    // ---------------------------------------------------------------
    // apb slave: no wait states, answer registered
    // ---------------------------------------------------------------
    next_r.pready = 1'b0;
    next_r.pslverr = 1'b0;
    if (psel && !penable) begin
      next_r.pready = 1'b1;
      next_r.prdata = 32'h00000000;
      case (paddr)
        CONTROL_OFFSET: begin
          next_r.prdata = {25'h0000000, r.chan_sel, r.delayed_release, r.sw_block,
                           r.force_status, r.force_en};
        end
        THRESHOLD_OFFSET: next_r.prdata = {16'h0000, r.threshold_value};
        DELAY_TYPE_OFFSET: next_r.prdata = {30'h00000000, r.delay_type};
        FIXED_DELAY_OFFSET: next_r.prdata = {13'h0000, r.fixed_delay};
        TIME_DIAL_OFFSET: next_r.prdata = {19'h00000, r.time_dial};
        EXPONENT_OFFSET: next_r.prdata = {20'h00000, r.exponent};
        RELEASE_DELAY_OFFSET: next_r.prdata = {13'h0000, r.release_delay};
        STATUS_OFFSET: begin
          next_r.prdata = {22'h000000, r.chan_code, 3'h0, r.hmi_flag, r.pickup,
                           r.blocked, r.trip, r.start};
        end
        EXPECTED_TIME_OFFSET: next_r.prdata = {13'h0000, r.expected};
        REMAINING_TIME_OFFSET: next_r.prdata = {13'h0000, r.remaining};
        RATIO_OFFSET: next_r.prdata = {15'h0000, r.ratio_pct};
        default: next_r.pslverr = 1'b1;
      endcase
    end
    if (access && pwrite) begin
      case (paddr)
        CONTROL_OFFSET: begin
          next_r.force_en = pwdata[CTRL_FORCE_EN_BIT];
          next_r.force_status = pwdata[CTRL_FORCE_LSB +: 2];
          next_r.sw_block = pwdata[CTRL_SW_BLOCK_BIT];
          next_r.delayed_release = pwdata[CTRL_DELAYED_REL_BIT];
          next_r.chan_sel = pwdata[CTRL_CHAN_LSB +: 2];
        end
        THRESHOLD_OFFSET: next_r.threshold_value = pwdata[15:0];
        DELAY_TYPE_OFFSET: next_r.delay_type = pwdata[1:0];
        FIXED_DELAY_OFFSET: next_r.fixed_delay = pwdata[18:0];
        TIME_DIAL_OFFSET: next_r.time_dial = pwdata[12:0];
        EXPONENT_OFFSET: next_r.exponent = pwdata[11:0];
        RELEASE_DELAY_OFFSET: next_r.release_delay = pwdata[18:0];
        STATUS_OFFSET: begin
          if (pwdata[STAT_HMI_FLAG_BIT]) begin
            next_r.hmi_flag = 1'b0;
          end
        end
        default: ;
      endcase
    end

    // ---------------------------------------------------------------
    // channel selection
    // ---------------------------------------------------------------
    case (r.chan_sel)
      2'h1, 2'h2: begin
        if (line_neutral_connected) begin
          sel_code = CHAN_CALC;
          sel_meas = calculated_residual;
        end
      end
      2'h3: begin
        if (third_channel_available) begin
          sel_code = CHAN_THIRD;
          sel_meas = third_channel_residual;
        end
      end
      default: begin
        if (fourth_channel_available) begin
          sel_code = CHAN_FOURTH;
          sel_meas = fourth_channel_residual;
        end
      end
    endcase

    // ---------------------------------------------------------------
    // processing cycle
    // ---------------------------------------------------------------
    next_r.block_event = 1'b0;
    if (r.tick_count >= TICK_CYCLES - 1) begin
      next_r.tick_count = 32'h00000000;
    end else begin
      next_r.tick_count = r.tick_count + 32'h00000001;
    end

    case (r.phase)
      PH_IDLE: begin
        if (r.tick_count >= TICK_CYCLES - 1) begin
          // blocking is latched before anything else is decided
          next_r.blk = block_in || (r.force_en && r.sw_block);
          next_r.measured_magnitude = sel_meas;
          next_r.chan_code = sel_code;
          next_r.div_q = {sel_meas, 16'h0000};
          next_r.div_rem = 33'h000000000;
          next_r.div_den = {16'h0000, r.threshold_value};
          next_r.div_iter = 6'd32;
          next_r.phase = PH_RATIO;
        end
      end
      PH_RATIO, PH_TIME: begin
        if (r.div_iter != 6'd0) begin
          shifted = {r.div_rem[31:0], r.div_q[31]};
          if (shifted >= {1'b0, r.div_den}) begin
            next_r.div_rem = shifted - {1'b0, r.div_den};
            next_r.div_q = {r.div_q[30:0], 1'b1};
          end else begin
            next_r.div_rem = shifted;
            next_r.div_q = {r.div_q[30:0], 1'b0};
          end
          next_r.div_iter = r.div_iter - 6'd1;
        end else if (r.phase == PH_RATIO) begin
          // a zero threshold divides to all ones, which reads as saturated
          next_r.ratio_q16 = r.div_q;
          // the quotient is truncated; one lsb up keeps exact ratios from reading a step low
          pct_wide = (48'(r.div_q) + 48'h000000000001) * 48'(PERCENT_SCALE);
          next_r.ratio_pct = (pct_wide[47:16] > 32'(MAX_RATIO_PCT)) ? MAX_RATIO_PCT
                             : pct_wide[32:16];
          // multiplier 655/65536 stands in for division by 100
          scaled_log = 42'(r.exponent) * 42'(log2_q16(r.div_q)) * 42'd655 >> 16;
          pow_q16 = exp2_q16(scaled_log);
          if (r.delay_type == INVERSE_DELAY_MODE) begin
            if (r.div_q <= 32'h00010000 || pow_q16 <= 32'h00010000) begin
              next_r.expected = MAX_OPERATE_TICKS;
              next_r.phase = PH_DECIDE;
            end else begin
              // dial is in 10 ms, two processing cycles per step
              next_r.div_q = {2'b00, r.time_dial, 1'b0, 16'h0000};
              next_r.div_rem = 33'h000000000;
              next_r.div_den = pow_q16 - 32'h00010000;
              next_r.div_iter = 6'd32;
              next_r.phase = PH_TIME;
            end
          end else begin
            next_r.expected = sat_ticks({13'h0000, r.fixed_delay});
            next_r.phase = PH_DECIDE;
          end
        end else begin
          next_r.expected = sat_ticks(r.div_q);
          next_r.phase = PH_DECIDE;
        end
      end
      PH_DECIDE: begin
        next_r.phase = PH_IDLE;
        meas_x100 = 23'(r.measured_magnitude) * 23'(PERCENT_SCALE);
        thr_x97 = 23'(r.threshold_value) * 23'(RESET_RATIO_PCT);
        if (r.pickup) begin
          pick_now = !(meas_x100 < thr_x97);
        end else begin
          pick_now = r.measured_magnitude > r.threshold_value;
        end
        if (r.chan_code == CHAN_NONE) begin
          pick_now = 1'b0;
        end
        next_r.pickup = pick_now;
        next_r.blocked_int = pick_now && r.blk;
        blocked_rise = pick_now && r.blk && !r.blocked_int;
        if (pick_now && !r.blk) begin
          next_r.start_int = 1'b1;
          next_r.releasing = 1'b0;
          if (!r.running) begin
            next_r.running = 1'b1;
            next_r.elapsed = 19'h00000;
            next_r.trip_int = (r.expected == 19'h00000);
          end else begin
            next_r.elapsed = (r.elapsed < MAX_OPERATE_TICKS) ? r.elapsed + 19'h00001
                             : r.elapsed;
            if (r.elapsed + 19'h00001 >= r.expected) begin
              next_r.trip_int = 1'b1;
            end
          end
        end else begin
          // pick-up gone or blocked: both go through release handling
          next_r.trip_int = 1'b0;
          next_r.start_int = 1'b0;
          if (r.running) begin
            if (!r.delayed_release || r.trip_int) begin
              next_r.running = 1'b0;
              next_r.releasing = 1'b0;
            end else if (!r.releasing) begin
              next_r.releasing = 1'b1;
              next_r.release_cnt = 19'h00000;
              next_r.start_int = !r.blk && (r.release_delay != 19'h00000);
              next_r.running = (r.release_delay != 19'h00000);
            end else if (r.release_cnt + 19'h00001 < r.release_delay) begin
              next_r.release_cnt = r.release_cnt + 19'h00001;
              next_r.start_int = !r.blk;
            end else begin
              next_r.releasing = 1'b0;
              next_r.running = 1'b0;
            end
          end
          if (pick_now && r.blk) begin
            next_r.running = r.running && r.delayed_release && !r.trip_int;
          end
        end
        if (next_r.running && !next_r.trip_int) begin
          next_r.remaining = (r.expected > next_r.elapsed) ? r.expected - next_r.elapsed
                             : 19'h00000;
        end else begin
          next_r.remaining = 19'h00000;
        end
        if (blocked_rise) begin
          next_r.block_event = 1'b1;
          next_r.event_voltage = r.measured_magnitude;
          next_r.event_fault_type = r.chan_code;
        end
      end
      default: next_r.phase = PH_IDLE;
    endcase

    // display flag: a new event wins over a clear in the same cycle
    if (blocked_rise) begin
      next_r.hmi_flag = 1'b1;
    end

    // ---------------------------------------------------------------
    // output stage with forcing
    // ---------------------------------------------------------------
    next_r.start = next_r.start_int;
    next_r.trip = next_r.trip_int;
    next_r.blocked = next_r.blocked_int;
    if (r.force_en) begin
      next_r.start = (r.force_status == FORCE_START) || (r.force_status == FORCE_TRIP);
      next_r.trip = (r.force_status == FORCE_TRIP);
      next_r.blocked = (r.force_status == FORCE_BLOCKED);
    end
  end

  // ----------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.delayed_release <= DELAYED_REL_RESET;
      r.chan_sel <= CHAN_SEL_RESET;
      r.threshold_value <= THRESHOLD_RESET;
      r.delay_type <= DELAY_TYPE_RESET;
      r.fixed_delay <= FIXED_DELAY_RESET;
      r.time_dial <= TIME_DIAL_RESET;
      r.exponent <= EXPONENT_RESET;
      r.release_delay <= RELEASE_DELAY_RESET;
      r.phase <= PH_IDLE;
    end else if (ce) begin
      r <= next_r;
    end
  end

  assign prdata = r.prdata;
  assign pready = r.pready;
  assign pslverr = r.pslverr;
  assign start = r.start;
  assign trip = r.trip;
  assign blocked = r.blocked;
  assign block_event = r.block_event;
  assign event_voltage = r.event_voltage;
  assign event_fault_type = r.event_fault_type;
  assign hmi_flag = r.hmi_flag;

endmodule : residual_overvoltage_stage

// ---- hw/neutral_overvoltage_pkg.sv ----
package neutral_overvoltage_pkg;

  // ----------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CONTROL_OFFSET = 8'h00;
  localparam logic [7:0] THRESHOLD_OFFSET = 8'h04;
  localparam logic [7:0] DELAY_TYPE_OFFSET = 8'h08;
  localparam logic [7:0] FIXED_DELAY_OFFSET = 8'h0C;
  localparam logic [7:0] TIME_DIAL_OFFSET = 8'h10;
  localparam logic [7:0] EXPONENT_OFFSET = 8'h14;
  localparam logic [7:0] RELEASE_DELAY_OFFSET = 8'h18;
  localparam logic [7:0] STATUS_OFFSET = 8'h1C;
  localparam logic [7:0] EXPECTED_TIME_OFFSET = 8'h20;
  localparam logic [7:0] REMAINING_TIME_OFFSET = 8'h24;
  localparam logic [7:0] RATIO_OFFSET = 8'h28;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CTRL_FORCE_EN_BIT = 0;
  localparam int CTRL_FORCE_LSB = 1;
  localparam int CTRL_SW_BLOCK_BIT = 3;
  localparam int CTRL_DELAYED_REL_BIT = 4;
  localparam int CTRL_CHAN_LSB = 5;
  localparam int STAT_HMI_FLAG_BIT = 4;
  localparam int STAT_CHAN_LSB = 8;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] THRESHOLD_RESET = 16'h07D0;
  localparam logic [1:0] DELAY_TYPE_RESET = 2'h1;
  localparam logic [18:0] FIXED_DELAY_RESET = 19'h00008;
  localparam logic [12:0] TIME_DIAL_RESET = 13'h0005;
  localparam logic [11:0] EXPONENT_RESET = 12'h064;
  localparam logic [18:0] RELEASE_DELAY_RESET = 19'h0000C;
  localparam logic [1:0] CHAN_SEL_RESET = 2'h1;
  localparam logic DELAYED_REL_RESET = 1'b1;

  // ----------------------------------------------------------------
  // codes and timing
  // ----------------------------------------------------------------
  localparam logic [1:0] FIXED_DELAY_MODE = 2'h1;
  localparam logic [1:0] INVERSE_DELAY_MODE = 2'h2;
  localparam logic [1:0] CHAN_NONE = 2'h0;
  localparam logic [1:0] CHAN_CALC = 2'h1;
  localparam logic [1:0] CHAN_THIRD = 2'h2;
  localparam logic [1:0] CHAN_FOURTH = 2'h3;
  localparam logic [1:0] FORCE_START = 2'h1;
  localparam logic [1:0] FORCE_TRIP = 2'h2;
  localparam logic [1:0] FORCE_BLOCKED = 2'h3;
  localparam logic [6:0] RESET_RATIO_PCT = 7'd97;
  localparam logic [6:0] PERCENT_SCALE = 7'd100;
  localparam int CLOCK_HZ = 50_000_000;
  localparam int CYCLE_TIME_MS = 5;
  localparam int TICK_CYCLES_DEFAULT = CLOCK_HZ / 1000 * CYCLE_TIME_MS;
  localparam logic [18:0] MAX_OPERATE_TICKS = 19'd360000;
  localparam logic [16:0] MAX_RATIO_PCT = 17'd125000;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_RATIO = 2'b01,
    PH_TIME = 2'b10,
    PH_DECIDE = 2'b11
  } phase_type;

endpackage : neutral_overvoltage_pkg

// ---- tb/front_end_model.sv ----
`timescale 1ns/100ps
module front_end_model #(
  parameter int TICK = 100
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [15:0] level_req,
  input wire logic block_req,
  output logic [15:0] calculated_residual,
  output logic [15:0] third_channel_residual,
  output logic [15:0] fourth_channel_residual,
  output logic block_in
);
  int cnt;
  // unselected channels carry churn so a wrong select shows up
  assign third_channel_residual = ~calculated_residual;
  assign fourth_channel_residual = calculated_residual ^ 16'h5A5A;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 0;
      calculated_residual <= 16'h0000;
      block_in <= 1'b0;
    end else begin
      cnt <= (cnt == TICK - 1) ? 0 : cnt + 1;
      if (cnt == TICK - 1) begin
        calculated_residual <= level_req;
        block_in <= block_req;
      end
    end
  end
endmodule : front_end_model

// ---- tb/neutral_overvoltage_checker.sv ----
`timescale 1ns/100ps
module neutral_overvoltage_checker (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic start,
  input wire logic trip,
  input wire logic blocked,
  input wire logic block_event,
  input wire logic hmi_flag
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles that start has stood, saturating, so the trip cover needs no long delay range
  logic [10:0] start_cycles;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start_cycles <= 11'h000;
    end else if (!start) begin
      start_cycles <= 11'h000;
    end else if (start_cycles != 11'h7FF) begin
      start_cycles <= start_cycles + 11'h001;
    end
  end
  property p_ready_after_setup; psel && !penable |=> pready; endproperty
  property p_ready_pulse; pready |=> !pready; endproperty
  property p_err_with_ready; pslverr |-> pready; endproperty
  property p_start_unblocked; start |-> !blocked; endproperty
  property p_trip_with_start; trip |-> start; endproperty
  property p_blocked_no_trip; blocked |-> !trip; endproperty
  property p_event_on_block; $rose(blocked) |-> ##[0:1] block_event; endproperty
  property p_event_pulse; block_event |=> !block_event && hmi_flag; endproperty
  a_ready_after_setup: assert property (p_ready_after_setup)
    else $error("no ready after setup");
  a_ready_pulse: assert property (p_ready_pulse) else $error("ready too long");
  a_err_with_ready: assert property (p_err_with_ready) else $error("error without ready");
  a_start_unblocked: assert property (p_start_unblocked) else $error("start while blocked");
  a_trip_with_start: assert property (p_trip_with_start) else $error("trip without start");
  a_blocked_no_trip: assert property (p_blocked_no_trip) else $error("trip while blocked");
  a_event_on_block: assert property (p_event_on_block) else $error("no block event");
  a_event_pulse: assert property (p_event_pulse) else $error("bad event pulse");
  c_trip: cover property ($rose(trip) && start_cycles > 11'h000 && start_cycles <= 11'h7D0);
  c_block: cover property (block_event);
  c_err: cover property (pslverr);
endmodule : neutral_overvoltage_checker

// ---- tb/residual_overvoltage_stage_tb.sv ----
`timescale 1ns/100ps
module residual_overvoltage_stage_tb;
  import neutral_overvoltage_pkg::*;
  localparam int TICK = 100;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, block_req = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, q, seed = 32'h56A0;
  logic pready, pslverr, err, start, trip, blocked, block_event, hmi_flag, block_in;
  logic [15:0] level_req = 16'h0000, cres, tres, fres, event_voltage;
  logic [1:0] event_fault_type;
  int errors = 0, samples_checked = 0, n, d;
  always #10 pclk = ~pclk;
  front_end_model #(.TICK(TICK)) fe_u (.pclk(pclk), .presetn(presetn), .level_req(level_req),
    .block_req(block_req), .calculated_residual(cres), .third_channel_residual(tres),
    .fourth_channel_residual(fres), .block_in(block_in));
  residual_overvoltage_stage #(.TICK_CYCLES(TICK)) dut_u (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .calculated_residual(cres),
    .third_channel_residual(tres), .fourth_channel_residual(fres),
    .line_neutral_connected(1'b1), .third_channel_available(1'b0),
    .fourth_channel_available(1'b0), .block_in(block_in), .start(start), .trip(trip),
    .blocked(blocked), .block_event(block_event), .event_voltage(event_voltage),
    .event_fault_type(event_fault_type), .hmi_flag(hmi_flag));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr
  task automatic stop_test();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : stop_test
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      errors++;
      $display("Error %0t got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] dat);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= dat;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    if (n >= 50) begin errors++; stop_test(); end
  endtask : apb
  task automatic wait_on(input int w);
    n = 0;
    while ((w == 0 ? start : w == 1 ? trip : blocked) !== 1'b1) begin
      @(posedge pclk);
      n++;
      if (n > 5000) begin errors++; stop_test(); end
    end
  endtask : wait_on
  task automatic ticks(input int k);
    repeat (k * TICK) @(posedge pclk);
  endtask : ticks
  logic [7:0] ra [6] = '{THRESHOLD_OFFSET, DELAY_TYPE_OFFSET, FIXED_DELAY_OFFSET,
    TIME_DIAL_OFFSET, EXPONENT_OFFSET, RELEASE_DELAY_OFFSET};
  logic [31:0] rv [6] = '{32'h7D0, 32'h1, 32'h8, 32'h5, 32'h64, 32'hC};
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ra[i], 32'h0);
      check(q, rv[i]);
    end
    apb(1'b0, 8'h40, 32'h0);
    check({31'h0, err}, 32'h1);
    check(q, 32'h0);
    // channel code is latched at each processing cycle, so wait for the first one
    ticks(1);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check(q[9:8], CHAN_CALC);
    apb(1'b1, CONTROL_OFFSET, 32'h20);
    // first pass instant, second a random short delay
    for (int i = 0; i < 2; i++) begin
      seed = lfsr(seed);
      d = (i == 0) ? 0 : seed[1:0] + 1;
      apb(1'b1, FIXED_DELAY_OFFSET, d);
      level_req <= 16'h7D1 + seed[8:0];
      wait_on(0);
      wait_on(1);
      check(n, d * TICK);
      apb(1'b0, RATIO_OFFSET, 32'h0);
      check(q, (32'h7D1 + seed[8:0]) * 100 / 2000);
      level_req <= 16'h0000;
      ticks(3);
    end
    apb(1'b1, FIXED_DELAY_OFFSET, 32'h14);
    level_req <= 16'h7D0;
    ticks(3);
    check(start, 1'b0);
    level_req <= 16'h7D1;
    wait_on(0);
    level_req <= 16'h7A8;
    ticks(3);
    check(start, 1'b1);
    level_req <= 16'h78A;
    ticks(3);
    check(start, 1'b0);
    block_req <= 1'b1;
    level_req <= 16'h9C4;
    wait_on(2);
    check({start, hmi_flag, event_voltage, event_fault_type}, {2'b01, 16'h9C4, CHAN_CALC});
    block_req <= 1'b0;
    level_req <= 16'h0000;
    ticks(3);
    level_req <= 16'h9C4;
    wait_on(0);
    block_req <= 1'b1;
    ticks(3);
    check(start, 1'b0);
    check(blocked, 1'b1);
    block_req <= 1'b0;
    level_req <= 16'h0000;
    apb(1'b1, STATUS_OFFSET, 32'h10);
    apb(1'b0, STATUS_OFFSET, 32'h0);
    check(q[4], 1'b0);
    ticks(3);
    // forcing: trip forced, then force status 0 with the software block switch on
    apb(1'b1, CONTROL_OFFSET, 32'h25);
    ticks(1);
    check({start, trip, blocked}, 3'b110);
    apb(1'b1, CONTROL_OFFSET, 32'h29);
    level_req <= 16'h9C4;
    ticks(3);
    check({start, blocked, hmi_flag}, 3'b001);
    level_req <= 16'h0000;
    ticks(3);
    apb(1'b1, CONTROL_OFFSET, 32'h20);
    apb(1'b1, DELAY_TYPE_OFFSET, INVERSE_DELAY_MODE);
    ticks(3);
    level_req <= 16'hFA0;
    wait_on(0);
    wait_on(1);
    check(n >= 9 * TICK && n <= 11 * TICK, 1'b1);
    stop_test();
  end
endmodule : residual_overvoltage_stage_tb
bind residual_overvoltage_stage neutral_overvoltage_checker chk_u (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .start(start), .trip(trip), .blocked(blocked), .block_event(block_event),
  .hmi_flag(hmi_flag));
